/* File: design/ctxb_cfg.svh */
`ifndef CTXB_CFG_SVH
`define CTXB_CFG_SVH

// Word index inside one buffer window; buffer n sits at word n*16
`define CTXB_REG_CTRL 4'h0
`define CTXB_REG_IDH  4'h1
`define CTXB_REG_IDL  4'h2
`define CTXB_REG_EIDH 4'h3
`define CTXB_REG_EIDL 4'h4
`define CTXB_REG_LEN  4'h5
`define CTXB_REG_DAT0 4'h6
`define CTXB_REG_DAT7 4'hd
// Transmit error count word
`define CTXB_REG_TEC  6'h30
`define CTXB_TEC_WIN  2'h3

// Control byte fields
`define CTXB_CTRL_DONE 7
`define CTXB_CTRL_ABT  6
`define CTXB_CTRL_LARB 5
`define CTXB_CTRL_BERR 4
`define CTXB_CTRL_REQ  3

// Reset values
`define CTXB_CTRL_RST 8'h00
`define CTXB_TEC_RST  8'h00

// Counts
`define CTXB_NBUF        3
`define CTXB_REC_SEQ_CNT 128
`define CTXB_TEC_ERR_INC 8
`define CTXB_TEC_OK_DEC  1

`endif

/* File: design/ctxb_pkg.sv */
`include "ctxb_cfg.svh"

package ctxb_pkg;

  typedef enum logic {
    CTXB_IDLE,
    CTXB_BUSY
  } ctxb_sched_e;

  typedef struct packed {
    logic                               waitrequest;
    logic [31:0]                        readdata;
    logic [`CTXB_NBUF-1:0]              tx_done_flag;
    logic [`CTXB_NBUF-1:0]              tx_aborted_status;
    logic [`CTXB_NBUF-1:0]              tx_lost_arbitration_status;
    logic [`CTXB_NBUF-1:0]              tx_bus_error_status;
    logic [`CTXB_NBUF-1:0]              tx_request;
    logic [`CTXB_NBUF-1:0][1:0]         tx_priority_level;
    logic [`CTXB_NBUF-1:0][7:0]         std_id_upper_bits;
    logic [`CTXB_NBUF-1:0][2:0]         std_id_lower_bits;
    logic [`CTXB_NBUF-1:0]              extended_format_select;
    logic [`CTXB_NBUF-1:0][1:0]         ext_id_bits_17_16;
    logic [`CTXB_NBUF-1:0][7:0]         ext_id_mid_byte;
    logic [`CTXB_NBUF-1:0][7:0]         ext_id_low_byte;
    logic [`CTXB_NBUF-1:0]              remote_frame_request;
    logic [`CTXB_NBUF-1:0][3:0]         dlc;
    logic [`CTXB_NBUF-1:0][7:0][7:0]    tx_payload_byte;
    ctxb_sched_e                        sched;
    logic [1:0]                         act;
    logic                               tx_valid;
    logic                               tx_abort;
    logic [28:0]                        tx_id;
    logic                               tx_ext;
    logic                               tx_rtr;
    logic [3:0]                         tx_dlc;
    logic [63:0]                        tx_data;
    logic [7:0]                         transmit_error_count_bits;
    logic                               bus_off;
    logic [6:0]                         rec_cnt;
  } ctxb_state_s;

endpackage

/* File: design/ctxb_top.sv */
`timescale 1ns/1ps
`include "ctxb_cfg.svh"
// Contract
// R1: Done flag sets when the buffer's message is sent; reads zero otherwise.
// R2: Software may clear the done flag; writing one never sets it.
// R3: Aborted status sets when a pending message is aborted, not sent.
// R4: Lost-arbitration status sets when the message loses arbitration.
// R5: Bus-error status sets when a bus error hits the message.
// R6: Setting the request clears aborted, lost-arbitration and bus-error status.
// R7: Request clears itself when the message is sent successfully.
// R8: While request is set, writes to that buffer are ignored.
// R9: Software clearing a set request asks to abort the message.
// R10: Priority 11 is highest level 3, 00 lowest level 0.
// R11: Priority only orders buffers, never alters the identifier.
// R12: Id high byte is std bits 10..3 or ext bits 28..21.
// R13: Id low byte holds std 2..0 or ext 20..18, plus ext 17..16.
// R14: Extended select sends 29-bit id; else 11-bit, ext bits ignored.
// R15: Two extra bytes hold ext bits 15..0, unused for standard frames.
// R16: Each buffer owns eight data bytes for its data field.
// R17: Remote request bit sets or clears the frame's remote bit.
// R18: Length codes 0..8 give 0..8 bytes; 9..15 reserved.
// R19: Unimplemented bits read zero.
// R20: Read-only 8-bit error count, zero at reset; overflow means bus-off.
// R21: Count clears after 128 runs of 11 recessive bits.
// R22: Equal priorities: the higher-numbered buffer goes first.
// R23: Count rises 8 per transmit error, falls 1 per success.

module ctxb_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             tx_valid,
  output logic             tx_abort,
  output logic      [1:0]  tx_buffer,
  output logic      [28:0] tx_id,
  output logic             tx_ext,
  output logic             tx_rtr,
  output logic      [3:0]  tx_dlc,
  output logic      [63:0] tx_data,
  input  wire logic        tx_ok,
  input  wire logic        tx_aborted,
  input  wire logic        tx_lost_arb,
  input  wire logic        tx_bus_err,
  input  wire logic        recessive_run,
  output logic             bus_off
);

  ctxb_pkg::ctxb_state_s st_reg;
  ctxb_pkg::ctxb_state_s st_next;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Register read decode
  function automatic logic [7:0] rd_byte(input ctxb_pkg::ctxb_state_s s,
                                         input logic [5:0] a);
    logic [1:0] b;
    logic [3:0] r;
    logic [7:0] v;
    b = a[5:4];
    r = a[3:0];
    v = 8'h00;
    if (a == `CTXB_REG_TEC) begin
      v = s.transmit_error_count_bits;
    end else if (b != `CTXB_TEC_WIN) begin
      // Unimplemented bits stay zero [R19]
      case (r)
        `CTXB_REG_CTRL: v = {s.tx_done_flag[b], s.tx_aborted_status[b],
                             s.tx_lost_arbitration_status[b],
                             s.tx_bus_error_status[b], s.tx_request[b],
                             1'b0, s.tx_priority_level[b]}; // [R19]
        `CTXB_REG_IDH:  v = s.std_id_upper_bits[b];
        `CTXB_REG_IDL:  v = {s.std_id_lower_bits[b], 1'b0,
                             s.extended_format_select[b], 1'b0,
                             s.ext_id_bits_17_16[b]}; // [R19]
        `CTXB_REG_EIDH: v = s.ext_id_mid_byte[b];
        `CTXB_REG_EIDL: v = s.ext_id_low_byte[b];
        `CTXB_REG_LEN:  v = {1'b0, s.remote_frame_request[b], 2'b00,
                             s.dlc[b]}; // [R19]
        default: begin
          if (r >= `CTXB_REG_DAT0 && r <= `CTXB_REG_DAT7) begin
            v = s.tx_payload_byte[b][3'(r - `CTXB_REG_DAT0)];
          end
        end
      endcase
    end
    return v;
  endfunction

  // Pending buffer with highest level, later index wins ties
  function automatic logic [1:0] pick(input logic [`CTXB_NBUF-1:0] rq,
                                      input logic [`CTXB_NBUF-1:0][1:0] pr);
    logic [1:0] w;
    logic [1:0] wp;
    logic       f;
    w  = 2'h0;
    wp = 2'h0;
    f  = 1'b0;
    for (int i = 0; i < `CTXB_NBUF; i++) begin
      if (rq[i] && (!f || pr[i] >= wp)) begin // [R10] [R22]
        w  = 2'(i);
        wp = pr[i];
        f  = 1'b1;
      end
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       wr_go;
    logic       busy;
    logic       act_b;
    logic [7:0] wd;
    logic [3:0] r;
    logic [8:0] sum;
    logic [1:0] a;
    wr_go = 1'b0;
    busy  = 1'b0;
    act_b = 1'b0;
    wd    = writedata[7:0];
    r     = address[3:0];
    sum   = 9'h000;
    a     = st_reg.act;
    st_next = st_reg;
    busy  = (st_reg.sched == ctxb_pkg::CTXB_BUSY);

    // Bus slave: one wait cycle, then a single answer cycle
    st_next.waitrequest = 1'b1;
    if ((read || write) && st_reg.waitrequest) begin
      st_next.waitrequest = 1'b0;
      st_next.readdata    = {24'h000000, rd_byte(st_reg, address)};
    end
    wr_go = write && !st_reg.waitrequest && byteenable[0];

    // Software writes, applied before hardware events so hardware events win
    for (int b = 0; b < `CTXB_NBUF; b++) begin
      act_b = busy && (st_reg.act == 2'(b));
      if (wr_go && address[5:4] == 2'(b)) begin
        if (r == `CTXB_REG_CTRL) begin
          if (st_reg.tx_request[b]) begin
            if (!wd[`CTXB_CTRL_REQ]) begin
              st_next.tx_request[b] = 1'b0; // [R9]
              if (act_b) begin
                st_next.tx_abort = 1'b1; // [R9]
              end else begin
                st_next.tx_aborted_status[b] = 1'b1; // [R3]
              end
            end
          end else if (!act_b) begin
            if (!wd[`CTXB_CTRL_DONE]) begin
              st_next.tx_done_flag[b] = 1'b0; // [R2]
            end
            st_next.tx_priority_level[b] = wd[1:0]; // [R10]
            if (wd[`CTXB_CTRL_REQ]) begin
              st_next.tx_request[b]                 = 1'b1;
              st_next.tx_aborted_status[b]          = 1'b0; // [R6]
              st_next.tx_lost_arbitration_status[b] = 1'b0; // [R6]
              st_next.tx_bus_error_status[b]        = 1'b0; // [R6]
            end
          end
        end else if (!st_reg.tx_request[b] && !act_b) begin // [R8]
          case (r)
            `CTXB_REG_IDH:  st_next.std_id_upper_bits[b] = wd;
            `CTXB_REG_IDL: begin
              st_next.std_id_lower_bits[b]      = wd[7:5];
              st_next.extended_format_select[b] = wd[3];
              st_next.ext_id_bits_17_16[b]      = wd[1:0];
            end
            `CTXB_REG_EIDH: st_next.ext_id_mid_byte[b] = wd;
            `CTXB_REG_EIDL: st_next.ext_id_low_byte[b] = wd;
            `CTXB_REG_LEN: begin
              st_next.remote_frame_request[b] = wd[6];
              st_next.dlc[b]                  = wd[3:0]; // [R18]
            end
            default: begin
              if (r >= `CTXB_REG_DAT0 && r <= `CTXB_REG_DAT7) begin
                st_next.tx_payload_byte[b][3'(r - `CTXB_REG_DAT0)] = wd; // [R16]
              end
            end
          endcase
        end
      end
    end

    // Scheduler and engine results
    case (st_reg.sched)
      ctxb_pkg::CTXB_IDLE: begin
        if (|st_reg.tx_request && !st_reg.bus_off) begin
          a = pick(st_reg.tx_request, st_reg.tx_priority_level); // [R10] [R22]
          st_next.act      = a;
          st_next.sched    = ctxb_pkg::CTXB_BUSY;
          st_next.tx_valid = 1'b1;
          st_next.tx_abort = 1'b0;
          st_next.tx_ext   = st_reg.extended_format_select[a];
          st_next.tx_rtr   = st_reg.remote_frame_request[a]; // [R17]
          st_next.tx_dlc   = st_reg.dlc[a]; // [R18]
          st_next.tx_data  = st_reg.tx_payload_byte[a]; // [R16]
          // Identifier built from id bytes only [R11]
          if (st_reg.extended_format_select[a]) begin
            st_next.tx_id = {st_reg.std_id_upper_bits[a],
                             st_reg.std_id_lower_bits[a],
                             st_reg.ext_id_bits_17_16[a],
                             st_reg.ext_id_mid_byte[a],
                             st_reg.ext_id_low_byte[a]}; // [R12] [R13] [R14] [R15]
          end else begin
            st_next.tx_id = {18'h00000, st_reg.std_id_upper_bits[a],
                             st_reg.std_id_lower_bits[a]}; // [R12] [R13] [R14]
          end
        end
      end
      ctxb_pkg::CTXB_BUSY: begin
        if (tx_ok || tx_aborted || tx_lost_arb || tx_bus_err) begin
          st_next.sched    = ctxb_pkg::CTXB_IDLE;
          st_next.tx_valid = 1'b0;
          st_next.tx_abort = 1'b0;
        end
        if (tx_ok) begin
          st_next.tx_done_flag[a] = 1'b1; // [R1]
          st_next.tx_request[a]   = 1'b0; // [R7]
          if (st_reg.transmit_error_count_bits != 8'h00) begin
            st_next.transmit_error_count_bits =
              st_reg.transmit_error_count_bits - 8'(`CTXB_TEC_OK_DEC); // [R23]
          end
        end else if (tx_aborted) begin
          st_next.tx_aborted_status[a] = 1'b1; // [R3]
          st_next.tx_request[a]        = 1'b0;
        end else if (tx_lost_arb) begin
          st_next.tx_lost_arbitration_status[a] = 1'b1; // [R4]
        end else if (tx_bus_err) begin
          st_next.tx_bus_error_status[a] = 1'b1; // [R5]
          sum = {1'b0, st_reg.transmit_error_count_bits} + 9'(`CTXB_TEC_ERR_INC);
          if (sum[8]) begin
            st_next.transmit_error_count_bits = 8'hff; // [R20]
            st_next.bus_off                   = 1'b1; // [R20]
          end else begin
            st_next.transmit_error_count_bits = sum[7:0]; // [R23]
          end
        end
      end
      default: begin
        st_next.sched    = ctxb_pkg::CTXB_IDLE;
        st_next.tx_valid = 1'b0;
      end
    endcase

    // Bus-off recovery on recessive runs
    if (st_reg.bus_off && recessive_run) begin
      if (st_reg.rec_cnt == 7'(`CTXB_REC_SEQ_CNT - 1)) begin
        st_next.transmit_error_count_bits = `CTXB_TEC_RST; // [R21]
        st_next.bus_off                   = 1'b0;
        st_next.rec_cnt                   = 7'h00;
      end else begin
        st_next.rec_cnt = st_reg.rec_cnt + 7'h01; // [R21]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg             <= '0; // [R20]
      st_reg.waitrequest <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign readdata    = st_reg.readdata;
  assign waitrequest = st_reg.waitrequest;
  assign tx_valid    = st_reg.tx_valid;
  assign tx_abort    = st_reg.tx_abort;
  assign tx_buffer   = st_reg.act;
  assign tx_id       = st_reg.tx_id;
  assign tx_ext      = st_reg.tx_ext;
  assign tx_rtr      = st_reg.tx_rtr;
  assign tx_dlc      = st_reg.tx_dlc;
  assign tx_data     = st_reg.tx_data;
  assign bus_off     = st_reg.bus_off;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic busy_chk;
  logic ctrl0_wr;
  assign busy_chk = (st_reg.sched == ctxb_pkg::CTXB_BUSY);
  assign ctrl0_wr = write && !waitrequest && byteenable[0] && address == 6'h00;

  property p_done_set;
    busy_chk && tx_ok |=> st_reg.tx_done_flag[$past(st_reg.act)] &&
                          !st_reg.tx_request[$past(st_reg.act)];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set"); // [R1] [R7]

  property p_done_cause;
    $rose(st_reg.tx_done_flag[0]) |-> $past(busy_chk && tx_ok && st_reg.act == 2'h0);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done set by sw"); // [R2]

  property p_abort_set;
    busy_chk && tx_aborted && !tx_ok |=> st_reg.tx_aborted_status[$past(st_reg.act)];
  endproperty
  a_abort_set: assert property (p_abort_set) else $error("abort lost"); // [R3]

  property p_larb_retry;
    busy_chk && tx_lost_arb && !tx_ok && !tx_aborted && st_reg.tx_request[st_reg.act]
      |=> st_reg.tx_lost_arbitration_status[$past(st_reg.act)] &&
          st_reg.tx_request[$past(st_reg.act)] && !tx_valid;
  endproperty
  a_larb_retry: assert property (p_larb_retry) else $error("larb bad"); // [R4]

  property p_berr_tec;
    busy_chk && tx_bus_err && !tx_ok && !tx_aborted && !tx_lost_arb && !recessive_run
      |=> st_reg.tx_bus_error_status[$past(st_reg.act)] &&
          (bus_off || st_reg.transmit_error_count_bits ==
           $past(st_reg.transmit_error_count_bits) + 8'h08);
  endproperty
  a_berr_tec: assert property (p_berr_tec) else $error("berr bad"); // [R5] [R23]

  property p_req_clears;
    ctrl0_wr && writedata[3] && !st_reg.tx_request[0] && !(busy_chk && st_reg.act == 2'h0)
      && !(busy_chk && st_reg.act == 2'h0)
      |=> st_reg.tx_request[0] && !st_reg.tx_aborted_status[0] &&
          !st_reg.tx_lost_arbitration_status[0] && !st_reg.tx_bus_error_status[0];
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("req set bad"); // [R6]

  property p_lock;
    write && !waitrequest && address == 6'h21 && st_reg.tx_request[2]
      |=> $stable(st_reg.std_id_upper_bits[2]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write taken"); // [R8]

  property p_tie;
    !busy_chk && !bus_off && st_reg.tx_request == 3'b110 &&
      st_reg.tx_priority_level[1] == st_reg.tx_priority_level[2]
      |=> tx_valid && tx_buffer == 2'h2;
  endproperty
  a_tie: assert property (p_tie) else $error("tie order bad"); // [R22]

  property p_std_id;
    $rose(tx_valid) && !tx_ext |-> tx_id[28:11] == 18'h00000;
  endproperty
  a_std_id: assert property (p_std_id) else $error("std id wide"); // [R14]

  property p_rtr_copy;
    $rose(tx_valid) |-> tx_rtr == st_reg.remote_frame_request[tx_buffer];
  endproperty
  a_rtr_copy: assert property (p_rtr_copy) else $error("remote bit bad"); // [R17]

  property p_no_start_off;
    bus_off |=> !$rose(tx_valid);
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("start in bus-off"); // [R20]

  property p_tec_clear;
    bus_off && recessive_run && st_reg.rec_cnt == 7'(`CTXB_REC_SEQ_CNT - 1)
      |=> !bus_off && st_reg.transmit_error_count_bits == `CTXB_TEC_RST;
  endproperty
  a_tec_clear: assert property (p_tec_clear) else $error("count not cleared"); // [R21]

endmodule

/* File: testbench/ctxb_bus_node_model.sv */
`timescale 1ns/1ps
// Behavioural stand-in for the protocol engine and the other bus nodes
module ctxb_bus_node_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       tx_valid,
  input  wire logic       tx_abort,
  input  wire logic       hold,
  input  wire logic [1:0] fault,
  output logic            tx_ok,
  output logic            tx_aborted,
  output logic            tx_lost_arb,
  output logic            tx_bus_err
);
  logic [2:0] wait_cnt;
  logic       answered;

  // One result pulse per frame, a few cycles in, only while a frame is offered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt    <= 3'h0;
      answered    <= 1'b0;
      tx_ok       <= 1'b0;
      tx_aborted  <= 1'b0;
      tx_lost_arb <= 1'b0;
      tx_bus_err  <= 1'b0;
    end else begin
      tx_ok       <= 1'b0;
      tx_aborted  <= 1'b0;
      tx_lost_arb <= 1'b0;
      tx_bus_err  <= 1'b0;
      if (!tx_valid) begin
        wait_cnt <= 3'h0;
        answered <= 1'b0;
      end else if (!answered && (!hold || tx_abort)) begin
        if (wait_cnt == 3'h3) begin
          answered <= 1'b1;
          // Abort request wins, even when the bus is held busy
          if (tx_abort) tx_aborted <= 1'b1;
          else if (fault == 2'h1) tx_lost_arb <= 1'b1;
          else if (fault == 2'h2) tx_bus_err <= 1'b1;
          else tx_ok <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`include "ctxb_cfg.svh"
module tb;
  logic        clk, reset_n, read, write, waitrequest, hold, recessive_run;
  logic        tx_valid, tx_abort, tx_ext, tx_rtr, bus_off;
  logic        tx_ok, tx_aborted, tx_lost_arb, tx_bus_err;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, tx_dlc;
  logic [1:0]  tx_buffer, fault, b;
  logic [28:0] tx_id;
  logic [63:0] tx_data;
  logic [7:0]  q;
  logic [28:0] eid [3];
  logic        eext [3];
  logic        ertr [3];
  logic [3:0]  edlc [3];
  logic [63:0] edat [3];
  logic [1:0]  p1 [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  logic [1:0]  p2 [4] = '{2'h2, 2'h2, 2'h0, 2'h1};
  logic [1:0]  first [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
  int          miscompares, checks, cycles;

  ctxb_top i_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .tx_valid(tx_valid), .tx_abort(tx_abort),
    .tx_buffer(tx_buffer), .tx_id(tx_id), .tx_ext(tx_ext), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .tx_ok(tx_ok), .tx_aborted(tx_aborted), .tx_lost_arb(tx_lost_arb),
    .tx_bus_err(tx_bus_err), .recessive_run(recessive_run), .bus_off(bus_off));
  ctxb_bus_node_model i_node (.clk(clk), .reset_n(reset_n), .tx_valid(tx_valid),
    .tx_abort(tx_abort), .hold(hold), .fault(fault), .tx_ok(tx_ok), .tx_aborted(tx_aborted),
    .tx_lost_arb(tx_lost_arb), .tx_bus_err(tx_bus_err));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  function automatic logic [5:0] ad(input int k, input logic [3:0] r);
    return {k[1:0], r};
  endfunction

  // One Avalon access, held until waitrequest is sampled low
  task automatic acc(input logic wr_en, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr_en;
    read <= !wr_en;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 4'hf);
    chk(nm, e, q);
  endtask

  // Wait for a frame offer, then for its withdrawal
  task automatic frame;
    while (tx_valid !== 1'b1) @(posedge clk);
    b = tx_buffer;
  endtask
  task automatic fall;
    while (tx_valid !== 1'b0) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic fchk(input logic [1:0] e);
    frame();
    chk("tx_buffer", e, b);
    chk("tx_id", eid[e], tx_id);
    chk("tx_ext", eext[e], tx_ext);
    chk("tx_rtr", ertr[e], tx_rtr);
    chk("tx_dlc", edlc[e], tx_dlc);
    chk("tx_data", edat[e], tx_data);
  endtask

  // Main sequence
  initial begin
    {read, write, hold, recessive_run, reset_n} = '0;
    {address, writedata, byteenable, fault} = '0;
    eid = '{29'h123, {8'h12, 3'h5, 2'h3, 16'h3456}, 29'h2a8};
    eext = '{1'b0, 1'b1, 1'b0};
    ertr = '{1'b1, 1'b0, 1'b0};
    edlc = '{4'hf, 4'h8, 4'h0};
    edat = '{64'h0, 64'h1716151413121110, 64'h0};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 3; k++) rc("ctrl", ad(k, `CTXB_REG_CTRL), `CTXB_CTRL_RST);
    rc("tec", `CTXB_REG_TEC, `CTXB_TEC_RST);
    wr(6'h0e, 8'hff);
    rc("unmapped", 6'h0e, 8'h00);
    $display("test reset_values done");
    wr(ad(0, `CTXB_REG_IDH), 8'h24);
    wr(ad(0, `CTXB_REG_IDL), 8'hff);
    rc("idl", ad(0, `CTXB_REG_IDL), 8'heb);
    wr(ad(0, `CTXB_REG_IDL), 8'h60);
    wr(ad(0, `CTXB_REG_EIDH), 8'haa);
    wr(ad(0, `CTXB_REG_LEN), 8'hff);
    rc("len", ad(0, `CTXB_REG_LEN), 8'h4f);
    wr(ad(2, `CTXB_REG_CTRL), 8'h07);
    rc("ctrl", ad(2, `CTXB_REG_CTRL), 8'h03);
    acc(1'b1, ad(0, `CTXB_REG_IDH), 8'h00, 4'h0);
    rc("idh", ad(0, `CTXB_REG_IDH), 8'h24);
    wr(ad(0, `CTXB_REG_CTRL), 8'h08);
    fchk(2'h0);
    fall();
    rc("ctrl", ad(0, `CTXB_REG_CTRL), 8'h80);
    wr(ad(0, `CTXB_REG_CTRL), 8'h80);
    rc("ctrl", ad(0, `CTXB_REG_CTRL), 8'h80);
    wr(ad(0, `CTXB_REG_CTRL), 8'h00);
    rc("ctrl", ad(0, `CTXB_REG_CTRL), 8'h00);
    $display("test standard_frame done");
    for (int m = 0; m < 8; m++) wr(ad(1, 4'(`CTXB_REG_DAT0 + m)), 8'(8'h10 + m));
    wr(ad(1, `CTXB_REG_IDH), 8'h12);
    wr(ad(1, `CTXB_REG_IDL), 8'hab);
    wr(ad(1, `CTXB_REG_EIDH), 8'h34);
    wr(ad(1, `CTXB_REG_EIDL), 8'h56);
    wr(ad(1, `CTXB_REG_LEN), 8'h08);
    wr(ad(1, `CTXB_REG_CTRL), 8'h08);
    fchk(2'h1);
    fall();
    $display("test extended_frame done");
    wr(ad(2, `CTXB_REG_IDH), 8'h55);
    wr(ad(2, `CTXB_REG_IDL), 8'h00);
    wr(ad(2, `CTXB_REG_LEN), 8'h00);
    hold <= 1'b1;
    wr(ad(2, `CTXB_REG_CTRL), 8'h0b);
    frame();
    wr(ad(2, `CTXB_REG_IDH), 8'hff);
    rc("idh", ad(2, `CTXB_REG_IDH), 8'h55);
    wr(ad(1, `CTXB_REG_CTRL), 8'h08);
    wr(ad(1, `CTXB_REG_CTRL), 8'h00);
    rc("ctrl", ad(1, `CTXB_REG_CTRL), 8'h40);
    wr(ad(2, `CTXB_REG_CTRL), 8'h00);
    chk("tx_abort", 1'b1, tx_abort);
    fall();
    rc("ctrl", ad(2, `CTXB_REG_CTRL), 8'h43);
    $display("test abort done");
    for (int k = 0; k < 4; k++) begin
      hold <= 1'b1;
      wr(ad(0, `CTXB_REG_CTRL), 8'h0b);
      frame();
      wr(ad(1, `CTXB_REG_CTRL), {6'h02, p1[k]});
      wr(ad(2, `CTXB_REG_CTRL), {6'h02, p2[k]});
      hold <= 1'b0;
      fall();
      fchk(first[k]);
      fall();
      fchk(2'h3 - first[k]);
      fall();
    end
    $display("test priority done");
    fault <= 2'h1;
    wr(ad(0, `CTXB_REG_CTRL), 8'h08);
    while (tx_lost_arb !== 1'b1) @(posedge clk);
    hold <= 1'b1;
    fault <= 2'h0;
    frame();
    rc("ctrl", ad(0, `CTXB_REG_CTRL), 8'h28);
    hold <= 1'b0;
    fall();
    acc(1'b0, ad(0, `CTXB_REG_CTRL), 8'h00, 4'hf);
    chk("ctrl", 8'h80, q & 8'h88);
    fault <= 2'h2;
    wr(ad(0, `CTXB_REG_CTRL), 8'h08);
    while (tx_bus_err !== 1'b1) @(posedge clk);
    hold <= 1'b1;
    fault <= 2'h0;
    frame();
    rc("ctrl", ad(0, `CTXB_REG_CTRL), 8'h18);
    rc("tec", `CTXB_REG_TEC, 8'h08);
    hold <= 1'b0;
    fall();
    rc("tec", `CTXB_REG_TEC, 8'h07);
    $display("test errors done");
    fault <= 2'h2;
    wr(ad(1, `CTXB_REG_CTRL), 8'h08);
    while (bus_off !== 1'b1) @(posedge clk);
    fault <= 2'h0;
    rc("tec", `CTXB_REG_TEC, 8'hff);
    for (int k = 0; k < `CTXB_REC_SEQ_CNT; k++) begin
      if (k == `CTXB_REC_SEQ_CNT - 1) chk("bus_off", 1'b1, bus_off);
      recessive_run <= 1'b1;
      @(posedge clk);
      recessive_run <= 1'b0;
      @(posedge clk);
    end
    chk("tx_valid", 1'b0, tx_valid);
    repeat (2) @(posedge clk);
    chk("bus_off", 1'b0, bus_off);
    rc("tec", `CTXB_REG_TEC, 8'h00);
    fchk(2'h1);
    fall();
    $display("test bus_off done");
    end_of_test();
  end
endmodule
